// ---- rtl/ulp_link_pm.sv ----
// The placing of the registers and the APB slave port are this design's own decisions.
`timescale 1ns/1ns
module ulp_link_pm #(
  parameter int RESUME_BASE_CYCLES = ulp_pkg::RESUME_BASE_CYC,
  parameter int RESUME_STEP_CYCLES = ulp_pkg::RESUME_STEP_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic host_mode,
  input wire ulp_pkg::ulp_tok_s tok,
  input wire logic tx_pending,
  input wire logic rx_pending,
  input wire logic bus_resume,
  input wire logic host_req_taken,
  input wire logic host_res_valid,
  input wire logic [2:0] host_res_code,
  output ulp_pkg::ulp_resp_s resp,
  output logic link_in_l1,
  output logic remote_wake_drive,
  output logic resume_drive,
  output logic host_req_valid,
  output logic [6:0] host_req_addr,
  output logic [3:0] host_req_ep,
  output logic host_req_grant_rw,
  output logic irq
);
  ulp_pkg::ulp_state_s s_q, s_d;
  logic [5:0] set_v;
  logic wr_done, rd_done, acc_go;

  // read mux, shared by capture logic
  function automatic logic [31:0] rd_word(input ulp_pkg::ulp_state_s s, input logic [7:0] a,
                                          input logic [5:0] fl);
    rd_word = 32'h00000000;
    case (a)
      ulp_pkg::OFS_CTRL: rd_word[3:0] = {s.arm, s.nak_sleep, s.policy};
      ulp_pkg::OFS_HCFG: rd_word[19:0] = {s.ep, 1'b0, s.addr, 2'h0, s.tgt_l1, s.grant_rw, s.res_steps};
      ulp_pkg::OFS_STAT: rd_word[5:0] = fl;
      ulp_pkg::OFS_IEN: rd_word[5:0] = s.ien;
      ulp_pkg::OFS_STATE: rd_word[9:0] = {s.hreq, s.rw_allowed, s.last_ep, 2'h0, s.arm, s.l1};
      default: rd_word = 32'h00000000;
    endcase
  endfunction : rd_word

  function automatic logic known_addr(input logic [7:0] a);
    known_addr = (a == ulp_pkg::OFS_CTRL) || (a == ulp_pkg::OFS_HCFG) || (a == ulp_pkg::OFS_STAT) ||
                 (a == ulp_pkg::OFS_IEN) || (a == ulp_pkg::OFS_STATE);
  endfunction : known_addr

  // apb phases: one wait state, effect at the completing edge
  assign acc_go = psel && penable && !s_q.pready;
  assign wr_done = psel && penable && s_q.pready && pwrite && known_addr(paddr);
  assign rd_done = psel && penable && s_q.pready && !pwrite && (paddr == ulp_pkg::OFS_STAT);

  always_comb begin
    s_d = s_q;
    set_v = 6'h00;
    s_d.resp = '0;
    s_d.pready = acc_go;
    s_d.pslverr = acc_go && !known_addr(paddr);
    // register writes
    if (wr_done && paddr == ulp_pkg::OFS_CTRL) begin
      s_d.policy = pwdata[1:0];
      s_d.nak_sleep = pwdata[ulp_pkg::CTRL_NAK];
      s_d.arm = pwdata[ulp_pkg::CTRL_ARM];
    end
    if (wr_done && paddr == ulp_pkg::OFS_HCFG) begin
      s_d.res_steps = pwdata[3:0];
      s_d.grant_rw = pwdata[4];
      s_d.tgt_l1 = pwdata[5];
      s_d.addr = pwdata[14:8];
      s_d.ep = pwdata[19:16];
    end
    if (wr_done && paddr == ulp_pkg::OFS_IEN) begin
      s_d.ien = pwdata[5:0];
    end
    // device side token answers
    if (!host_mode && tok.valid) begin
      if (tok.lpm && s_q.policy == ulp_pkg::POLICY_FULL_RESPONSE) begin
        s_d.last_ep = tok.ep;
        s_d.resp.valid = 1'b1;
        if (tok.bad_ls) begin
          s_d.resp.code = ulp_pkg::RSP_STALL;
          set_v[ulp_pkg::FL_STALL] = 1'b1;
          set_v[ulp_pkg::FL_ERROR] = 1'b1;
        end else if (!s_q.arm || s_q.l1) begin
          s_d.resp.code = ulp_pkg::RSP_NYET;
          set_v[ulp_pkg::FL_NYET] = 1'b1;
        end else if (tx_pending) begin
          s_d.resp.code = ulp_pkg::RSP_NYET;
          set_v[ulp_pkg::FL_INCOMPLETE] = 1'b1;
        end else if (rx_pending) begin
          s_d.resp.code = ulp_pkg::RSP_NYET;
          set_v[ulp_pkg::FL_NYET] = 1'b1;
        end else begin
          s_d.resp.code = ulp_pkg::RSP_ACK;
          s_d.l1 = 1'b1;
          s_d.st = ulp_pkg::ST_SLEEP;
          s_d.arm = 1'b0;
          s_d.rw_allowed = tok.rwake;
          set_v[ulp_pkg::FL_ACK] = 1'b1;
        end
      end else if (tok.ext && !tok.lpm && s_q.policy != ulp_pkg::POLICY_IGNORE_SLEEP) begin
        s_d.resp.valid = 1'b1;
        s_d.resp.code = ulp_pkg::RSP_ACK;
      end else if (!tok.lpm && !tok.ext && s_q.l1 && s_q.nak_sleep) begin
        s_d.resp.valid = 1'b1;
        s_d.resp.code = ulp_pkg::RSP_NAK;
      end
    end
    // host side request queue and outcomes
    if (wr_done && paddr == ulp_pkg::OFS_CTRL && host_mode && pwdata[ulp_pkg::CTRL_SEND] && !s_q.l1) begin
      s_d.hreq = 1'b1;
      s_d.errcnt = 2'h0;
    end else if (host_req_taken) begin
      s_d.hreq = 1'b0;
    end
    if (host_mode && host_res_valid) begin
      case (host_res_code)
        ulp_pkg::HR_ACK: begin
          s_d.l1 = 1'b1;
          s_d.st = ulp_pkg::ST_SLEEP;
          s_d.rw_allowed = s_q.grant_rw;
          set_v[ulp_pkg::FL_ACK] = 1'b1;
        end
        ulp_pkg::HR_NYET: set_v[ulp_pkg::FL_NYET] = 1'b1;
        ulp_pkg::HR_STALL: set_v[ulp_pkg::FL_STALL] = 1'b1;
        ulp_pkg::HR_TIMEOUT: set_v[ulp_pkg::FL_INCOMPLETE] = 1'b1;
        ulp_pkg::HR_BITERR: begin
          set_v[ulp_pkg::FL_ERROR] = 1'b1;
          if (s_q.errcnt == ulp_pkg::BITERR_LAST) begin
            set_v[ulp_pkg::FL_INCOMPLETE] = 1'b1;
            s_d.errcnt = 2'h0;
          end else begin
            s_d.errcnt = s_q.errcnt + 2'h1;
            s_d.hreq = 1'b1;
          end
        end
        default: set_v[ulp_pkg::FL_ERROR] = 1'b1;
      endcase
    end
    // link sleep and wake sequencing
    case (s_q.st)
      ulp_pkg::ST_SLEEP: begin
        if (bus_resume) begin
          s_d.st = ulp_pkg::ST_IDLE;
          s_d.l1 = 1'b0;
          set_v[ulp_pkg::FL_RESUME] = 1'b1;
        end else if (wr_done && paddr == ulp_pkg::OFS_CTRL && host_mode && pwdata[ulp_pkg::CTRL_RESUME]) begin
          s_d.st = ulp_pkg::ST_WAKE;
          s_d.resume_drv = 1'b1;
          s_d.timer = 16'(RESUME_BASE_CYCLES + int'(s_q.res_steps) * RESUME_STEP_CYCLES - 1);
        end else if (wr_done && paddr == ulp_pkg::OFS_CTRL && !host_mode && pwdata[ulp_pkg::CTRL_RWAKE] &&
                     s_q.rw_allowed) begin
          s_d.st = ulp_pkg::ST_WAKE;
          s_d.wake_drv = 1'b1;
          s_d.timer = 16'(RESUME_BASE_CYCLES - 1);
        end
      end
      ulp_pkg::ST_WAKE: begin
        // drivers hold until the count runs out; bus resume cannot cut it short
        if (s_q.timer == 16'h0000) begin
          s_d.st = ulp_pkg::ST_IDLE;
          s_d.l1 = 1'b0;
          s_d.resume_drv = 1'b0;
          s_d.wake_drv = 1'b0;
          set_v[ulp_pkg::FL_RESUME] = 1'b1;
        end else begin
          s_d.timer = s_q.timer - 16'h0001;
        end
      end
      ulp_pkg::ST_IDLE: s_d.timer = 16'h0000;
      default: s_d.st = ulp_pkg::ST_IDLE;
    endcase
    // status: read clears, but a set in the same cycle survives
    s_d.flags = (rd_done ? 6'h00 : s_q.flags) | set_v;
    s_d.irq = |(s_d.flags & s_q.ien);
    s_d.prdata = acc_go ? rd_word(s_q, paddr, s_q.flags | set_v) : s_q.prdata;
  end

  // single state register, everything cleared at reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign resp = s_q.resp;
  assign link_in_l1 = s_q.l1;
  assign remote_wake_drive = s_q.wake_drv;
  assign resume_drive = s_q.resume_drv;
  assign host_req_valid = s_q.hreq;
  assign host_req_addr = s_q.addr;
  assign host_req_ep = s_q.ep;
  assign host_req_grant_rw = s_q.grant_rw;
  assign irq = s_q.irq;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic dev_ok_tok;
  assign dev_ok_tok = !host_mode && tok.valid && tok.lpm && !tok.bad_ls &&
                      s_q.policy == ulp_pkg::POLICY_FULL_RESPONSE && s_q.arm && !s_q.l1;

  sequence seq_ack_out;
    resp.valid && resp.code == ulp_pkg::RSP_ACK && link_in_l1;
  endsequence

  chk_no_unarmed_sleep: assert property ($rose(link_in_l1) && !$past(host_mode) |-> $past(s_q.arm))
    else $error("entered sleep without arm");
  chk_arm_self_clear: assert property ($rose(link_in_l1) && !$past(host_mode) |-> !s_q.arm)
    else $error("arm not cleared on sleep entry");
  chk_ack_entry: assert property (dev_ok_tok && !tx_pending && !rx_pending |=> seq_ack_out ##0 s_q.flags[0])
    else $error("empty fifos did not give ack and sleep");
  chk_nyet_pending: assert property (dev_ok_tok && tx_pending |=> resp.code == ulp_pkg::RSP_NYET &&
                                      s_q.flags[ulp_pkg::FL_INCOMPLETE] && !link_in_l1)
    else $error("pending data did not give nyet");
  chk_extonly_quiet: assert property (!host_mode && tok.valid && tok.lpm &&
                                      s_q.policy == ulp_pkg::POLICY_EXTENDED_ONLY |=> !resp.valid)
    else $error("extended only policy answered sleep");
  chk_nak_asleep: assert property (!host_mode && tok.valid && !tok.lpm && !tok.ext && s_q.l1 && s_q.nak_sleep
                                   |=> resp.valid && resp.code == ulp_pkg::RSP_NAK)
    else $error("missing nak while asleep");
  chk_silent_asleep: assert property (!host_mode && tok.valid && !tok.lpm && !tok.ext && s_q.l1 && !s_q.nak_sleep
                                      |=> !resp.valid)
    else $error("answered while asleep without nak");
  chk_stat_clear: assert property (rd_done |=> s_q.flags == $past(set_v))
    else $error("status read did not clear");
  chk_resume_hold: assert property ($rose(resume_drive) |-> resume_drive [*5])
    else $error("resume signalling too short");

  // length of the drive pulse now on the bus, judged when the pulse ends
  // kept outside the state struct: it only serves the checks below
  logic [15:0] drv_len_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drv_len_q <= 16'h0000;
    end else if (resume_drive || remote_wake_drive) begin
      drv_len_q <= drv_len_q + 16'h0001;
    end else begin
      drv_len_q <= 16'h0000;
    end
  end

  // full resume length from the programmed step count
  chk_resume_len: assert property ($fell(resume_drive) |->
                                   drv_len_q == 16'(RESUME_BASE_CYCLES + int'(s_q.res_steps) * RESUME_STEP_CYCLES))
    else $error("resume length differs from programmed steps");
  // remote wake runs for the base length only
  chk_wake_len: assert property ($fell(remote_wake_drive) |-> drv_len_q == 16'(RESUME_BASE_CYCLES))
    else $error("remote wake length wrong");
  // remote wake only when the last accepted request granted it
  chk_rwake_gate: assert property ($rose(remote_wake_drive) |-> $past(s_q.rw_allowed) && !$past(host_mode))
    else $error("remote wake without grant");
  // ignore policy stays silent on sleep requests
  chk_ignore_quiet: assert property (!host_mode && tok.valid && tok.lpm &&
                                     s_q.policy == ulp_pkg::POLICY_IGNORE_SLEEP |=> !resp.valid)
    else $error("ignore policy answered sleep");
  // a send command only queues the request
  chk_host_queue: assert property (wr_done && paddr == ulp_pkg::OFS_CTRL && host_mode &&
                                   pwdata[ulp_pkg::CTRL_SEND] && !s_q.l1 |=> host_req_valid)
    else $error("send command did not queue request");
  // third bit error in a row gives up with incomplete
  chk_biterr_limit: assert property (host_mode && host_res_valid && host_res_code == ulp_pkg::HR_BITERR &&
                                     s_q.errcnt == ulp_pkg::BITERR_LAST |=> s_q.flags[ulp_pkg::FL_INCOMPLETE])
    else $error("bit errors did not end in incomplete");
  // resume seen on the bus while asleep leaves the sleep state
  chk_bus_wake: assert property (s_q.st == ulp_pkg::ST_SLEEP && bus_resume |=>
                                 !link_in_l1 && s_q.flags[ulp_pkg::FL_RESUME])
    else $error("bus resume did not leave sleep");
  // APB ready is a single-cycle pulse
  chk_pready_pulse: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  chk_irq_follow: assert property (|(s_q.flags & s_q.ien) |-> irq || $past(rd_done) || $changed(s_q.ien))
    else $error("enabled flag without interrupt");
endmodule : ulp_link_pm

// ---- rtl/ulp_pkg.sv ----
package ulp_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_HCFG = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h08;
  localparam logic [7:0] OFS_IEN = 8'h0C;
  localparam logic [7:0] OFS_STATE = 8'h10;
  // control fields
  localparam int CTRL_NAK = 2;
  localparam int CTRL_ARM = 3;
  localparam int CTRL_RWAKE = 4;
  localparam int CTRL_RESUME = 5;
  localparam int CTRL_SEND = 6;
  // answering policies
  localparam logic [1:0] POLICY_IGNORE_SLEEP = 2'h0;
  localparam logic [1:0] POLICY_FULL_RESPONSE = 2'h1;
  localparam logic [1:0] POLICY_EXTENDED_ONLY = 2'h2;
  // status flag positions
  localparam int FL_ACK = 0;
  localparam int FL_NYET = 1;
  localparam int FL_INCOMPLETE = 2;
  localparam int FL_STALL = 3;
  localparam int FL_RESUME = 4;
  localparam int FL_ERROR = 5;
  // bus answer codes
  localparam logic [2:0] RSP_ACK = 3'h0;
  localparam logic [2:0] RSP_NYET = 3'h1;
  localparam logic [2:0] RSP_NAK = 3'h2;
  localparam logic [2:0] RSP_STALL = 3'h3;
  // host outcome codes
  localparam logic [2:0] HR_ACK = 3'h0;
  localparam logic [2:0] HR_NYET = 3'h1;
  localparam logic [2:0] HR_STALL = 3'h2;
  localparam logic [2:0] HR_TIMEOUT = 3'h3;
  localparam logic [2:0] HR_BITERR = 3'h4;
  localparam logic [1:0] BITERR_LAST = 2'h2;
  // timing
  localparam int CLK_MHZ = 50;
  localparam int RESUME_BASE_US = 50;
  localparam int RESUME_STEP_US = 75;
  localparam int RESUME_BASE_CYC = RESUME_BASE_US * CLK_MHZ;
  localparam int RESUME_STEP_CYC = RESUME_STEP_US * CLK_MHZ;

  typedef enum logic [1:0] {ST_IDLE, ST_SLEEP, ST_WAKE} ulp_st_e;

  typedef struct packed {
    logic valid;
    logic lpm;
    logic ext;
    logic bad_ls;
    logic [3:0] ep;
    logic rwake;
  } ulp_tok_s;

  typedef struct packed {
    logic valid;
    logic [2:0] code;
  } ulp_resp_s;

  typedef struct packed {
    logic [1:0] policy;
    logic nak_sleep;
    logic arm;
    logic [3:0] res_steps;
    logic grant_rw;
    logic tgt_l1;
    logic [6:0] addr;
    logic [3:0] ep;
    logic [5:0] flags;
    logic [5:0] ien;
    ulp_st_e st;
    logic l1;
    logic [15:0] timer;
    logic [3:0] last_ep;
    logic rw_allowed;
    logic hreq;
    logic [1:0] errcnt;
    ulp_resp_s resp;
    logic wake_drv;
    logic resume_drv;
    logic irq;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } ulp_state_s;
endpackage : ulp_pkg

// ---- tb/ulp_far_end.sv ----
`timescale 1ns/1ns
module ulp_far_end (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic host_req_valid,
  input wire logic [2:0] res_code,
  output logic host_req_taken,
  output logic host_res_valid,
  output logic [2:0] host_res_code
);
  // bus engine: takes each queued request, answers after a short flight
  // idle code lines show the inverse so a stale value never passes
  initial begin
    host_req_taken = 1'b0;
    host_res_valid = 1'b0;
    host_res_code = 3'h7;
    forever begin
      @(posedge pclk);
      if (presetn && host_req_valid) begin
        host_req_taken <= 1'b1;
        @(posedge pclk);
        host_req_taken <= 1'b0;
        repeat (3) @(posedge pclk);
        host_res_valid <= 1'b1;
        host_res_code <= res_code;
        @(posedge pclk);
        host_res_valid <= 1'b0;
        host_res_code <= ~res_code;
      end
    end
  end
endmodule : ulp_far_end

// ---- tb/tb_top.sv ----
`timescale 1ns/1ns
module tb_top;
  localparam int RB = 5;
  localparam int RS = 4;
  logic pclk, presetn, psel, penable, pwrite, host_mode, tx_pending, rx_pending, bus_resume;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, seed;
  logic pready, pslverr, er, link_in_l1, remote_wake_drive, resume_drive, irq;
  logic host_req_valid, host_req_grant_rw, host_req_taken, host_res_valid;
  logic [6:0] host_req_addr;
  logic [3:0] host_req_ep, ep, st;
  logic [2:0] host_res_code, hcode;
  ulp_pkg::ulp_tok_s tok;
  ulp_pkg::ulp_resp_s resp;
  int fails, n_tests, n;

  ulp_link_pm #(.RESUME_BASE_CYCLES(RB), .RESUME_STEP_CYCLES(RS)) ulp_link_pm_inst (
    .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
    .host_mode, .tok, .tx_pending, .rx_pending, .bus_resume, .host_req_taken, .host_res_valid,
    .host_res_code, .resp, .link_in_l1, .remote_wake_drive, .resume_drive, .host_req_valid,
    .host_req_addr, .host_req_ep, .host_req_grant_rw, .irq
  );
  ulp_far_end ulp_far_end_inst (
    .pclk, .presetn, .host_req_valid, .res_code(hcode), .host_req_taken, .host_res_valid, .host_res_code
  );

  // free running clock, 20 ns
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction : xs

  function automatic logic [31:0] fl(input int i);
    return 32'h1 << i;
  endfunction : fl

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // apb master: request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) fails++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd, exp);
  endtask : rdchk

  // one token, then the one-cycle answer {valid, code}
  task automatic tk(input logic l, input logic x, input logic rw, input logic [3:0] exp);
    @(posedge pclk);
    tok <= '{1'b1, l, x, 1'b0, ep, rw};
    @(posedge pclk);
    tok.valid <= 1'b0;
    #1;
    check({28'h0, resp.valid, resp.code}, {28'h0, exp});
  endtask : tk

  // length of a drive pulse in cycles, bounded wait for its start
  task automatic span(input logic s, output int c);
    int w;
    c = 0;
    w = 0;
    while ((s ? resume_drive : remote_wake_drive) !== 1'b1 && w < 50) begin
      @(posedge pclk);
      w++;
    end
    while ((s ? resume_drive : remote_wake_drive) === 1'b1 && c < 5000) begin
      @(posedge pclk);
      c++;
    end
  endtask : span

  task automatic print_verdict();
    $display("fails=%0d n_tests=%0d", fails, n_tests);
    if (fails == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : print_verdict

  // watchdog well beyond the few hundred cycles of the run
  initial begin
    #400000;
    fails++;
    print_verdict();
  end

  // main sequence: device role first, then host role
  initial begin
    logic [2:0] hc [2];
    hc = '{ulp_pkg::HR_TIMEOUT, ulp_pkg::HR_BITERR};
    {presetn, psel, penable, pwrite, host_mode, tx_pending, rx_pending, bus_resume} = 8'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    tok = '0;
    hcode = ulp_pkg::HR_ACK;
    fails = 0;
    n_tests = 0;
    seed = xs(32'h74693866);
    ep = seed[3:0];
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(ulp_pkg::OFS_STATE, 32'h0);
    rdchk(ulp_pkg::OFS_STAT, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    check({31'h0, er}, 32'h1);
    check(rd, 32'h0);
    apb(1'b1, ulp_pkg::OFS_IEN, 32'h3F);
    apb(1'b1, ulp_pkg::OFS_CTRL, 32'h8);
    tk(1'b1, 1'b0, 1'b0, 4'h0);
    check(link_in_l1, 1'b0);
    apb(1'b1, ulp_pkg::OFS_CTRL, 32'h1);
    tk(1'b1, 1'b0, 1'b0, {1'b1, ulp_pkg::RSP_NYET});
    rdchk(ulp_pkg::OFS_STAT, fl(ulp_pkg::FL_NYET));
    rdchk(ulp_pkg::OFS_STAT, 32'h0);
    // armed with data pending, transmit then receive
    apb(1'b1, ulp_pkg::OFS_CTRL, 32'h9);
    tx_pending <= 1'b1;
    tk(1'b1, 1'b0, 1'b0, {1'b1, ulp_pkg::RSP_NYET});
    rdchk(ulp_pkg::OFS_STAT, fl(ulp_pkg::FL_INCOMPLETE));
    tx_pending <= 1'b0;
    rx_pending <= 1'b1;
    tk(1'b1, 1'b0, 1'b0, {1'b1, ulp_pkg::RSP_NYET});
    rdchk(ulp_pkg::OFS_STAT, fl(ulp_pkg::FL_NYET));
    rx_pending <= 1'b0;
    seed = xs(seed);
    ep = seed[3:0];
    tk(1'b1, 1'b0, 1'b1, {1'b1, ulp_pkg::RSP_ACK});
    check(link_in_l1, 1'b1);
    repeat (2) @(posedge pclk);
    check(irq, 1'b1);
    rdchk(ulp_pkg::OFS_STATE, {ep, 4'h1} | 32'h100);
    rdchk(ulp_pkg::OFS_STAT, fl(ulp_pkg::FL_ACK));
    repeat (2) @(posedge pclk);
    check(irq, 1'b0);
    tk(1'b0, 1'b0, 1'b0, 4'h0);
    apb(1'b1, ulp_pkg::OFS_CTRL, 32'h5);
    tk(1'b0, 1'b0, 1'b0, {1'b1, ulp_pkg::RSP_NAK});
    tk(1'b1, 1'b0, 1'b0, {1'b1, ulp_pkg::RSP_NYET});
    apb(1'b0, ulp_pkg::OFS_STAT, 32'h0);
    apb(1'b1, ulp_pkg::OFS_CTRL, 32'h15);
    span(1'b0, n);
    check(n, RB);
    rdchk(ulp_pkg::OFS_STAT, fl(ulp_pkg::FL_RESUME));
    // no re-arm after resume: sleep refused
    tk(1'b1, 1'b0, 1'b0, {1'b1, ulp_pkg::RSP_NYET});
    check(link_in_l1, 1'b0);
    apb(1'b1, ulp_pkg::OFS_CTRL, 32'h9);
    tk(1'b1, 1'b0, 1'b0, {1'b1, ulp_pkg::RSP_ACK});
    bus_resume <= 1'b1;
    @(posedge pclk);
    bus_resume <= 1'b0;
    repeat (2) @(posedge pclk);
    check(link_in_l1, 1'b0);
    apb(1'b1, ulp_pkg::OFS_CTRL, 32'hA);
    tk(1'b1, 1'b0, 1'b0, 4'h0);
    tk(1'b0, 1'b1, 1'b0, {1'b1, ulp_pkg::RSP_ACK});
    check(link_in_l1, 1'b0);
    // host role: queued request to a random address and endpoint
    host_mode <= 1'b1;
    apb(1'b0, ulp_pkg::OFS_STAT, 32'h0);
    seed = xs(seed);
    st = seed[3:0];
    ep = seed[11:8];
    if (seed[22:16] == 7'h0) seed[16] = 1'b1;
    apb(1'b1, ulp_pkg::OFS_HCFG, {ep, 1'b0, seed[22:16], 8'h30} | st);
    apb(1'b1, ulp_pkg::OFS_CTRL, 32'h40);
    #1;
    check({host_req_valid, host_req_grant_rw, host_req_ep, host_req_addr}, {2'h3, ep, seed[22:16]});
    check(irq, 1'b0);
    repeat (10) @(posedge pclk);
    rdchk(ulp_pkg::OFS_STAT, fl(ulp_pkg::FL_ACK));
    apb(1'b1, ulp_pkg::OFS_CTRL, 32'h20);
    span(1'b1, n);
    check(n, RB + RS * st);
    rdchk(ulp_pkg::OFS_STAT, fl(ulp_pkg::FL_RESUME));
    foreach (hc[i]) begin
      hcode = hc[i];
      apb(1'b1, ulp_pkg::OFS_CTRL, 32'h40);
      repeat (40) @(posedge pclk);
      apb(1'b0, ulp_pkg::OFS_STAT, 32'h0);
      check(rd & 32'h5, fl(ulp_pkg::FL_INCOMPLETE));
    end
    print_verdict();
  end
endmodule : tb_top
